/* File: design/isstr_force_conversion.sv */
`include "isstr_map.svh"
`timescale 1ns/1ps

module isstr_force_conversion #(
  parameter logic [31:0] PERIOD_CYCLES = `ISSTR_CLK_HZ * `ISSTR_PERIOD_S
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  isstr_force_conversion_if.eng       cv,
  input  wire logic [9:0] temp_sample,
  input  wire logic [7:0] cap_code_calc,
  output logic      [7:0] cap_code,
  output logic            sensor_convert
);
  import isstr_pkg::*;

  localparam logic [31:0] FORCE_CONVERSION_CYCLES =
    (`ISSTR_CLK_HZ / `ISSTR_HZ_PER_MHZ) * `ISSTR_FORCE_CONVERSION_US;

  isstr_force_conversion_st_t c_q;
  isstr_force_conversion_st_t c_d;
  logic           frc;
  logic           period_hit;
  logic [9:0]     sum;

  always_comb begin
    c_d        = c_q;
    c_d.done   = 1'b0;
    c_d.force_q = cv.force_force_conversion;
    frc        = cv.force_force_conversion && !c_q.force_q;
    period_hit = (c_q.tick == PERIOD_CYCLES - 32'h0000_0001);
    c_d.tick   = period_hit ? 32'h0000_0000 : c_q.tick + 32'h0000_0001;
    sum = {2'b00, cap_code_calc} + {{2{cv.aging[7]}}, cv.aging};
    case (c_q.st)
      FORCE_CONVERSION_IDLE: begin
        if (period_hit || cv.access || frc) begin
          c_d.st     = FORCE_CONVERSION_RUN;
          c_d.run    = 32'h0000_0000;
          c_d.forced = frc;
        end
      end
      FORCE_CONVERSION_RUN: begin
        if (frc) begin
          c_d.forced = 1'b1;
        end
        if (c_q.run == FORCE_CONVERSION_CYCLES - 32'h0000_0001) begin
          c_d.st   = FORCE_CONVERSION_IDLE;
          c_d.done = 1'b1;
          c_d.temp = temp_sample;
          if (c_q.forced || temp_sample != c_q.temp) begin
            if (sum[9]) begin
              c_d.cap = 8'h00;
            end else if (sum[8]) begin
              c_d.cap = 8'hFF;
            end else begin
              c_d.cap = sum[7:0];
            end
          end
        end else begin
          c_d.run = c_q.run + 32'h0000_0001;
        end
      end
      default: begin
        c_d.st = FORCE_CONVERSION_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      // Power-up starts a forced conversion at once from a 0 degC reading.
      c_q <= '{st: FORCE_CONVERSION_RUN, forced: 1'b1, temp: `ISSTR_TEMP_RST,
               default: '0};
    end else begin
      c_q <= c_d;
    end
  end

  assign cv.busy        = (c_q.st == FORCE_CONVERSION_RUN);
  assign sensor_convert = (c_q.st == FORCE_CONVERSION_RUN);
  assign cv.done        = c_q.done;
  assign cv.temp        = c_q.temp;
  assign cap_code       = c_q.cap;
endmodule

/* File: design/isstr_force_conversion_if.sv */
`timescale 1ns/1ps

interface isstr_force_conversion_if;
  logic       force_force_conversion;
  logic       access;
  logic [7:0] aging;
  logic       busy;
  logic       done;
  logic [9:0] temp;

  modport ctl (output force_force_conversion, access, aging, input busy, done, temp);
  modport eng (input force_force_conversion, access, aging, output busy, done, temp);
endinterface

/* File: design/isstr_map.svh */
`ifndef ISSTR_MAP_SVH
`define ISSTR_MAP_SVH

// ==========================================================================
// Register offsets
`define ISSTR_REG_STATUS    8'h0F
`define ISSTR_REG_AGING     8'h10
`define ISSTR_REG_TEMP_INT  8'h11
`define ISSTR_REG_TEMP_FRAC 8'h12
`define ISSTR_REG_LAST      8'h12

// ==========================================================================
// Bus address and field positions
`define ISSTR_SLAVE_ADDR    7'h68
`define ISSTR_BYTE_BITS     4'h8
`define ISSTR_BIT_OSF       3'h7
`define ISSTR_BIT_EN32      3'h3
`define ISSTR_BIT_BUSY      3'h2
`define ISSTR_BIT_A2F       3'h1
`define ISSTR_BIT_A1F       3'h0

// ==========================================================================
// Reset values
`define ISSTR_OSF_RST       1'h1
`define ISSTR_EN32_RST      1'h1
`define ISSTR_AGING_RST     8'h00
`define ISSTR_TEMP_RST      10'h000

// ==========================================================================
// Timing
`define ISSTR_CLK_HZ        32'h0131_2D00
`define ISSTR_HZ_PER_MHZ    32'h000F_4240
`define ISSTR_PERIOD_S      32'h0000_0040
`define ISSTR_FORCE_CONVERSION_US       32'h0000_00C8
`define ISSTR_WAVE_HZ       32'h0000_8000

`endif

/* File: design/isstr_pkg.sv */
package isstr_pkg;

  typedef enum logic [5:0] {
    BUS_IDLE  = 6'h01,
    BUS_ADDR  = 6'h02,
    BUS_WDATA = 6'h04,
    BUS_ACK   = 6'h08,
    BUS_RDATA = 6'h10,
    BUS_RACK  = 6'h20
  } isstr_bus_e_t;

  typedef enum logic [1:0] {
    FORCE_CONVERSION_IDLE = 2'h1,
    FORCE_CONVERSION_RUN  = 2'h2
  } isstr_force_conversion_e_t;

  typedef struct packed {
    isstr_bus_e_t st;
    logic [3:0]   bits;
    logic [7:0]   sh;
    logic [7:0]   ptr;
    logic         got_ptr;
    logic         rw;
    logic         nack;
    logic         sda_oe;
    logic         scl_q;
    logic         sda_q;
    logic         oscillator_stop_flag;
    logic         en32;
    logic         a2f;
    logic         a1f;
    logic [7:0]   aging;
    logic [8:0]   div;
    logic         wave;
    logic         int_oe;
    logic         access;
  } isstr_bus_st_t;

  typedef struct packed {
    isstr_force_conversion_e_t st;
    logic [31:0]   tick;
    logic [31:0]   run;
    logic          forced;
    logic          force_q;
    logic [9:0]    temp;
    logic [7:0]    cap;
    logic          done;
  } isstr_force_conversion_st_t;

endpackage

/* File: design/isstr_regs_i2c.sv */
// What this block does
// - Oscillator stop flag sets whenever the oscillator stops; stays until written 0.
// - Stop flag also sets at power-up and on battery-mode oscillator disable.
// - Clock output enable drives 32.768 kHz square wave; otherwise pin floats.
// - Clock output enable resets to 1; wave runs if oscillator runs.
// - Conversion busy rises with sensor convert, clears when processing idles.
// - Alarm 2 match sets second flag; pin asserts if enabled and selected.
// - Alarm 1 match sets first flag; pin asserts if enabled and selected.
// - Writing 0 clears an alarm flag; writing 1 leaves it unchanged.
// - Aging trim is two's complement, sign in bit 7, one capacitor per LSB.
// - Trim is added on changed-temperature periodic and on forced conversions.
// - Positive trim raises capacitance code, negative lowers it.
// - Temperature is 10-bit two's complement quarter degrees at 11h and 12h.
// - Power reset loads 0 degC and starts a conversion immediately.
// - Conversions at power-up, battery-mode access, then periodically; registers update.
// - Temperature registers are read-only; serial writes are ignored.
// - Device is slave only, for 100 kHz and 400 kHz masters.
// - Data falling with clock high is START; rising is STOP.
// - Data changes only while clock low; one clock pulse per bit.
// - Bytes move MSB first with ninth acknowledge; master sets byte count.
// - Receiver holds data low through the high phase of the acknowledge pulse.
// - Master ends read with no acknowledge; slave releases data line.
// - Only slave address 1101000 answers; direction bit 0 write, 1 read.
// - First written byte loads the pointer; later bytes write and increment.
// - Reads start at the current pointer, kept from the previous access.
`include "isstr_map.svh"
`timescale 1ns/1ps

module isstr_regs_i2c #(
  parameter logic [31:0] PERIOD_CYCLES = `ISSTR_CLK_HZ * `ISSTR_PERIOD_S
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       osc_stopped,
  input  wire logic       battery_mode,
  input  wire logic       battery_osc_disable,
  input  wire logic       force_conversion,
  input  wire logic       first_alarm_match,
  input  wire logic       second_alarm_match,
  input  wire logic       first_alarm_irq_enable,
  input  wire logic       second_alarm_irq_enable,
  input  wire logic       interrupt_select,
  input  wire logic [9:0] temp_sample,
  input  wire logic [7:0] cap_code_calc,
  output logic      [7:0] cap_code,
  output logic            sensor_convert,
  output logic            conversion_busy,
  output logic            conversion_done,
  output logic            clk32k_out,
  output logic            clk32k_oe,
  output logic            interrupt_wave_pin_n_out,
  output logic            interrupt_wave_pin_n_oe
);
  import isstr_pkg::*;

  // ========================================================================
  // Constants and helpers
  localparam logic [8:0] HALF_WAVE =
    9'(`ISSTR_CLK_HZ / (32'h0000_0002 * `ISSTR_WAVE_HZ));

  function automatic logic [7:0] nxt_ptr(input logic [7:0] p);
    nxt_ptr = (p == `ISSTR_REG_LAST) ? 8'h00 : p + 8'h01;
  endfunction

  function automatic logic [7:0] rd_reg(
    input logic [7:0]    a,
    input isstr_bus_st_t s,
    input logic          busy,
    input logic [9:0]    t
  );
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `ISSTR_REG_STATUS: begin
        v[`ISSTR_BIT_OSF]  = s.oscillator_stop_flag;
        v[`ISSTR_BIT_EN32] = s.en32;
        v[`ISSTR_BIT_BUSY] = busy;
        v[`ISSTR_BIT_A2F]  = s.a2f;
        v[`ISSTR_BIT_A1F]  = s.a1f;
      end
      `ISSTR_REG_AGING:     v = s.aging;
      `ISSTR_REG_TEMP_INT:  v = t[9:2];
      `ISSTR_REG_TEMP_FRAC: v = {t[1:0], 6'h00};
      default:              v = 8'h00;
    endcase
    rd_reg = v;
  endfunction

  // ========================================================================
  // Input synchronisers and conversion engine
  logic [3:0] sy;
  logic       scl_s;
  logic       sda_s;
  logic       osc_stop_s;
  logic       batt_s;

  isstr_sync #(
    .W (4)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       ({battery_mode, osc_stopped, sda_in, scl}),
    .q       (sy)
  );

  assign scl_s      = sy[0];
  assign sda_s      = sy[1];
  assign osc_stop_s = sy[2];
  assign batt_s     = sy[3];

  isstr_force_conversion_if cvi ();

  isstr_force_conversion #(
    .PERIOD_CYCLES (PERIOD_CYCLES)
  ) u_force_conversion (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .cv             (cvi),
    .temp_sample    (temp_sample),
    .cap_code_calc  (cap_code_calc),
    .cap_code       (cap_code),
    .sensor_convert (sensor_convert)
  );

  // ========================================================================
  // Serial slave and register slice
  isstr_bus_st_t q;
  isstr_bus_st_t d;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_c;
  logic          stop_c;
  logic          osc_run;
  logic          load;
  logic [7:0]    rd_byte;

  assign scl_rise = scl_s && !q.scl_q;
  assign scl_fall = !scl_s && q.scl_q;
  assign start_c  = scl_s && q.scl_q && q.sda_q && !sda_s;
  assign stop_c   = scl_s && q.scl_q && !q.sda_q && sda_s;
  // Oscillator counts as stopped when battery mode disables it.
  assign osc_run  = !osc_stop_s && !(batt_s && battery_osc_disable);
  assign rd_byte  = rd_reg(q.ptr, q, cvi.busy, cvi.temp);

  always_comb begin
    d        = q;
    d.scl_q  = scl_s;
    d.sda_q  = sda_s;
    d.access = 1'b0;
    load     = 1'b0;
    if (start_c) begin
      d.st      = BUS_ADDR;
      d.bits    = 4'h0;
      d.got_ptr = 1'b0;
      d.sda_oe  = 1'b0;
    end else if (stop_c) begin
      d.st     = BUS_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        BUS_IDLE: begin
          d.sda_oe = 1'b0;
        end
        BUS_ADDR, BUS_WDATA: begin
          if (scl_rise && q.bits < `ISSTR_BYTE_BITS) begin
            d.sh   = {q.sh[6:0], sda_s};
            d.bits = q.bits + 4'h1;
          end else if (scl_fall && q.bits == `ISSTR_BYTE_BITS) begin
            d.bits = 4'h0;
            if (q.st == BUS_ADDR) begin
              if (q.sh[7:1] == `ISSTR_SLAVE_ADDR) begin
                d.rw     = q.sh[0];
                d.sda_oe = 1'b1;
                d.st     = BUS_ACK;
                d.access = batt_s;
              end else begin
                d.st = BUS_IDLE;
              end
            end else begin
              d.sda_oe = 1'b1;
              d.st     = BUS_ACK;
              if (!q.got_ptr) begin
                d.ptr     = q.sh;
                d.got_ptr = 1'b1;
              end else begin
                case (q.ptr)
                  `ISSTR_REG_STATUS: begin
                    d.oscillator_stop_flag  = q.oscillator_stop_flag & q.sh[`ISSTR_BIT_OSF];
                    d.en32 = q.sh[`ISSTR_BIT_EN32];
                    d.a2f  = q.a2f & q.sh[`ISSTR_BIT_A2F];
                    d.a1f  = q.a1f & q.sh[`ISSTR_BIT_A1F];
                  end
                  `ISSTR_REG_AGING: begin
                    d.aging = q.sh;
                  end
                  // Temperature and unmapped offsets ignore the data.
                  default: begin
                    d.aging = q.aging;
                  end
                endcase
                d.ptr = nxt_ptr(q.ptr);
              end
            end
          end
        end
        BUS_ACK: begin
          if (scl_fall) begin
            d.sda_oe = 1'b0;
            if (q.rw) begin
              load = 1'b1;
            end else begin
              d.st = BUS_WDATA;
            end
          end
        end
        BUS_RDATA: begin
          if (scl_fall) begin
            if (q.bits == 4'h7) begin
              d.sda_oe = 1'b0;
              d.st     = BUS_RACK;
            end else begin
              d.sh     = {q.sh[6:0], 1'b0};
              d.sda_oe = !q.sh[6];
              d.bits   = q.bits + 4'h1;
            end
          end
        end
        BUS_RACK: begin
          if (scl_rise) begin
            d.nack = sda_s;
          end
          if (scl_fall) begin
            if (q.nack) begin
              d.st = BUS_IDLE;
            end else begin
              load = 1'b1;
            end
          end
        end
        default: begin
          d.st     = BUS_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end
    if (load) begin
      d.sh     = rd_byte;
      d.sda_oe = !rd_byte[7];
      d.ptr    = nxt_ptr(q.ptr);
      d.bits   = 4'h0;
      d.st     = BUS_RDATA;
    end
    // Hardware sets take priority over a software clear in the same cycle.
    if (!osc_run) begin
      d.oscillator_stop_flag = 1'b1;
    end
    if (second_alarm_match) begin
      d.a2f = 1'b1;
    end
    if (first_alarm_match) begin
      d.a1f = 1'b1;
    end
    d.int_oe = interrupt_select &&
               ((q.a1f && first_alarm_irq_enable) ||
                (q.a2f && second_alarm_irq_enable));
    if (osc_run) begin
      if (q.div == HALF_WAVE - 9'h001) begin
        d.div  = 9'h000;
        d.wave = !q.wave;
      end else begin
        d.div = q.div + 9'h001;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q <= '{st:    BUS_IDLE,
             scl_q: 1'b1,
             sda_q: 1'b1,
             oscillator_stop_flag:   `ISSTR_OSF_RST,
             en32:  `ISSTR_EN32_RST,
             aging: `ISSTR_AGING_RST,
             default: '0};
    end else begin
      q <= d;
    end
  end

  // ========================================================================
  // Outputs
  assign cvi.force_force_conversion = force_conversion;
  assign cvi.access     = q.access;
  assign cvi.aging      = q.aging;

  assign sda_out                  = 1'b0;
  assign sda_oe                   = q.sda_oe;
  assign clk32k_out               = q.wave;
  assign clk32k_oe                = q.en32;
  assign interrupt_wave_pin_n_out = 1'b0;
  assign interrupt_wave_pin_n_oe  = q.int_oe;
  assign conversion_busy          = cvi.busy;
  assign conversion_done          = cvi.done;
endmodule

/* File: design/isstr_sync.sv */
`timescale 1ns/1ps

module isstr_sync #(
  parameter int W = 4
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import isstr_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } isstr_sync_st_t;

  isstr_sync_st_t r_q;
  isstr_sync_st_t r_d;

  always_comb begin
    r_d    = r_q;
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r_q <= '{s1: '1, s2: '1};
    end else begin
      r_q <= r_d;
    end
  end

  assign q = r_q.s2;
endmodule

/* File: test/isstr_i2c_master.sv */
`timescale 1ns/1ps
// ==========================================================================
// Bus master model: owns the clock, pulls data low through open drain.
module isstr_i2c_master (
  input wire logic ref_clk,
  input wire logic sda_oe,
  output logic     scl,
  output logic     sda_in
);
  logic pull_q;

  // The data line has a pull-up, so it reads high unless someone pulls it.
  assign sda_in = !(pull_q || sda_oe);

  initial begin
    scl = 1'b1;
    pull_q = 1'b0;
  end

  task automatic quarter();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // Sends one bit (1 releases the line) and returns what the line held.
  task automatic bit_io(input logic b, output logic s);
    quarter();
    pull_q = !b;
    quarter();
    scl = 1'b1;
    quarter();
    s = sda_in;
    quarter();
    scl = 1'b0;
  endtask

  task automatic start();
    wait (scl && sda_in);
    quarter();
    pull_q = 1'b1;
    quarter();
    scl = 1'b0;
  endtask

  task automatic stop();
    quarter();
    pull_q = 1'b1;
    quarter();
    scl = 1'b1;
    quarter();
    pull_q = 1'b0;
    quarter();
  endtask

  task automatic byte_io(input logic [7:0] tx, input logic ack_in,
                         output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack);
  endtask
endmodule

/* File: test/isstr_monitor.sv */
`timescale 1ns/1ps
// ==========================================================================
// Checker for the status, trim and temperature slice.
module isstr_monitor (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       first_alarm_match,
  input wire logic       second_alarm_match,
  input wire logic       first_alarm_irq_enable,
  input wire logic       second_alarm_irq_enable,
  input wire logic       interrupt_select,
  input wire logic       osc_stopped,
  input wire logic       battery_mode,
  input wire logic       battery_osc_disable,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic [7:0] cap_code,
  input wire logic       sensor_convert,
  input wire logic       conversion_busy,
  input wire logic       conversion_done,
  input wire logic       clk32k_out,
  input wire logic       clk32k_oe,
  input wire logic       interrupt_wave_pin_n_oe
);
  localparam int FORCE_CONVERSION_LO = 3996;
  localparam int FORCE_CONVERSION_HI = 4002;
  localparam int WAVE_HALF = 305;
  logic [12:0] run_q;
  logic [9:0]  half_q;
  logic        clean_q;
  logic        int_ok;

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (rst);

  assign int_ok = interrupt_select &&
                  (first_alarm_irq_enable || second_alarm_irq_enable);

  // Wave half periods are only judged after a full toggle with osc running.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      run_q <= 13'h0000;
      half_q <= 10'h000;
      clean_q <= 1'b0;
    end else begin
      run_q <= conversion_busy ? run_q + 13'h0001 : 13'h0000;
      half_q <= $changed(clk32k_out) ? 10'h001 : half_q + 10'h001;
      if (osc_stopped || (battery_mode && battery_osc_disable))
        clean_q <= 1'b0;
      else if ($changed(clk32k_out))
        clean_q <= 1'b1;
    end
  end

  sequence s_int_up;
    ##[1:2] interrupt_wave_pin_n_oe;
  endsequence

  sequence s_alarm1;
    first_alarm_match && first_alarm_irq_enable && interrupt_select;
  endsequence

  sequence s_alarm2;
    second_alarm_match && second_alarm_irq_enable && interrupt_select;
  endsequence

  chk_int_first: assert property (
    s_alarm1 |-> s_int_up) else $error("pin missed alarm one");
  chk_int_second: assert property (
    s_alarm2 |-> s_int_up) else $error("pin missed alarm two");
  chk_int_quiet: assert property (
    !int_ok && !$past(int_ok) |-> !interrupt_wave_pin_n_oe)
    else $error("pin asserted while masked");
  chk_busy_mirror: assert property (
    conversion_busy == sensor_convert) else $error("busy differs");
  chk_force_conversion_length: assert property (
    $fell(conversion_busy) |-> run_q inside {[FORCE_CONVERSION_LO:FORCE_CONVERSION_HI]})
    else $error("conversion length wrong");
  chk_done_single: assert property (
    conversion_done |=> !conversion_done) else $error("done too long");
  chk_done_ends: assert property (
    conversion_done |-> ##[0:1] !conversion_busy)
    else $error("busy stayed after done");
  chk_cap_at_done: assert property (
    $changed(cap_code) |-> conversion_done || $past(conversion_done))
    else $error("cap code moved without conversion");
  chk_wave_period: assert property (
    clean_q && $changed(clk32k_out) |-> half_q == WAVE_HALF)
    else $error("wave half period wrong");
  chk_enable_reset: assert property (
    $fell(rst) |-> clk32k_oe) else $error("wave output off at reset");
  chk_open_drain: assert property (
    sda_oe |-> !sda_out) else $error("data driven high");
endmodule

bind isstr_regs_i2c isstr_monitor isstr_monitor_inst (
  .ref_clk(ref_clk), .rst(rst), .first_alarm_match(first_alarm_match),
  .second_alarm_match(second_alarm_match),
  .first_alarm_irq_enable(first_alarm_irq_enable),
  .second_alarm_irq_enable(second_alarm_irq_enable),
  .interrupt_select(interrupt_select), .osc_stopped(osc_stopped),
  .battery_mode(battery_mode), .battery_osc_disable(battery_osc_disable),
  .sda_out(sda_out), .sda_oe(sda_oe), .cap_code(cap_code),
  .sensor_convert(sensor_convert), .conversion_busy(conversion_busy),
  .conversion_done(conversion_done), .clk32k_out(clk32k_out),
  .clk32k_oe(clk32k_oe),
  .interrupt_wave_pin_n_oe(interrupt_wave_pin_n_oe));

/* File: test/tb_isstr_regs_i2c.sv */
`timescale 1ns/1ps
`include "isstr_map.svh"
// ==========================================================================
// Self-checking bench; the periodic interval is shortened to keep runs short.
module tb_isstr_regs_i2c;
  localparam logic [31:0] PERIOD = 32'h0000_4E20;
  logic       ref_clk, rst, scl, sda_in, sda_out, sda_oe, osc_stopped;
  logic       battery_mode, battery_osc_disable, force_conversion;
  logic       interrupt_select, sensor_convert, conversion_busy;
  logic       conversion_done, clk32k_out, clk32k_oe, int_out, int_oe;
  logic [1:0] am, ie;
  logic [9:0] temp_sample;
  logic [7:0] cap_code_calc, cap_code;
  int         miscompares, checked;

  isstr_regs_i2c #(.PERIOD_CYCLES(PERIOD)) isstr_regs_i2c_inst (
    .ref_clk(ref_clk), .rst(rst), .scl(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .osc_stopped(osc_stopped),
    .battery_mode(battery_mode), .battery_osc_disable(battery_osc_disable),
    .force_conversion(force_conversion), .first_alarm_match(am[0]),
    .second_alarm_match(am[1]), .first_alarm_irq_enable(ie[0]),
    .second_alarm_irq_enable(ie[1]), .interrupt_select(interrupt_select),
    .temp_sample(temp_sample), .cap_code_calc(cap_code_calc),
    .cap_code(cap_code), .sensor_convert(sensor_convert),
    .conversion_busy(conversion_busy), .conversion_done(conversion_done),
    .clk32k_out(clk32k_out), .clk32k_oe(clk32k_oe),
    .interrupt_wave_pin_n_out(int_out), .interrupt_wave_pin_n_oe(int_oe));

  isstr_i2c_master isstr_i2c_master_inst (
    .ref_clk(ref_clk), .sda_oe(sda_oe), .scl(scl), .sda_in(sda_in));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic results();
    if (miscompares == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // First byte is the pointer, the rest land at successive offsets.
  task automatic wr(input logic [7:0] b[$]);
    logic [7:0] r;
    logic       a;
    isstr_i2c_master_inst.start();
    isstr_i2c_master_inst.byte_io({`ISSTR_SLAVE_ADDR, 1'b0}, 1'b1, r, a);
    check({7'h00, a}, 8'h00);
    foreach (b[i]) begin
      isstr_i2c_master_inst.byte_io(b[i], 1'b1, r, a);
      check({7'h00, a}, 8'h00);
    end
    isstr_i2c_master_inst.stop();
  endtask

  task automatic rd(input int n, output logic [7:0] got[$]);
    logic [7:0] r;
    logic       a;
    got = {};
    isstr_i2c_master_inst.start();
    isstr_i2c_master_inst.byte_io({`ISSTR_SLAVE_ADDR, 1'b1}, 1'b1, r, a);
    check({7'h00, a}, 8'h00);
    for (int i = 0; i < n; i++) begin
      isstr_i2c_master_inst.byte_io(8'hFF, i == n - 1, r, a);
      got.push_back(r);
    end
    isstr_i2c_master_inst.stop();
  endtask

  task automatic wait_done(input int limit);
    int k;
    k = 0;
    while (conversion_done !== 1'b1 && k < limit) begin
      cycles(1);
      k++;
    end
    check({7'h00, conversion_done}, 8'h01);
    cycles(1);
  endtask

  function automatic logic [7:0] cap_exp(input logic [7:0] c,
                                         input logic [7:0] t);
    int s;
    s = int'(c) + int'($signed(t));
    return (s < 0) ? 8'h00 : (s > 255) ? 8'hFF : 8'(s);
  endfunction

  initial begin
    repeat (100000) @(posedge ref_clk);
    miscompares++;
    results();
  end

  initial begin
    logic [7:0] got[$];
    logic [7:0] tv, cv, adr, r;
    logic [9:0] ts, pt;
    logic       a;
    {rst, osc_stopped, battery_mode, battery_osc_disable} = 4'h8;
    {force_conversion, am, ie, interrupt_select} = 6'h01;
    temp_sample = 10'h000;
    cap_code_calc = 8'h80;
    void'($urandom(70));
    cycles(10);
    rst = 1'b0;
    cycles(3);
    check({7'h00, clk32k_oe}, 8'h01);
    wr({`ISSTR_REG_STATUS});
    rd(4, got);
    check(got[0], 8'h8C);
    check(got[1], 8'h00);
    check(got[2], 8'h00);
    check(got[3], 8'h00);
    wait_done(6000);
    wr({`ISSTR_REG_STATUS, 8'h00});
    check({7'h00, clk32k_oe}, 8'h00);
    wr({`ISSTR_REG_STATUS});
    rd(1, got);
    check(got[0] & 8'hFB, 8'h00);
    for (int k = 0; k < 2; k++) begin
      if (k == 0)
        osc_stopped = 1'b1;
      else
        {battery_mode, battery_osc_disable} = 2'b11;
      cycles(8);
      {osc_stopped, battery_mode, battery_osc_disable} = 3'h0;
      cycles(8);
      wr({`ISSTR_REG_STATUS});
      rd(1, got);
      check(got[0] & 8'hFB, 8'h80 | {4'h0, k[0], 3'h0});
      wr({`ISSTR_REG_STATUS, 8'h08});
    end
    for (int k = 0; k < 3; k++) begin
      a = (k != 0);
      interrupt_select = (k != 2);
      ie = 2'b01 << a;
      am = 2'b01 << a;
      cycles(1);
      am = 2'b00;
      cycles(3);
      check({7'h00, int_oe}, {7'h00, k != 2});
      wr({`ISSTR_REG_STATUS, 8'h0B});
      wr({`ISSTR_REG_STATUS});
      rd(1, got);
      check(got[0] & 8'hFB, 8'h08 | (8'h01 << a));
      wr({`ISSTR_REG_STATUS, 8'h08});
      cycles(3);
      check({7'h00, int_oe}, 8'h00);
    end
    pt = 10'h000;
    for (int k = 0; k < 4; k++) begin
      tv = (k == 0) ? 8'h7F : (k == 1) ? 8'h80 : 8'($urandom());
      cv = (k == 0) ? 8'hF0 : (k == 1) ? 8'h10 : 8'($urandom());
      ts = 10'($urandom());
      wr({`ISSTR_REG_AGING, tv, 8'h55});
      rd(1, got);
      check(got[0], {pt[1:0], 6'h00});
      temp_sample = ts;
      cap_code_calc = cv;
      force_conversion = 1'b1;
      wait_done(6000);
      force_conversion = 1'b0;
      check(cap_code, cap_exp(cv, tv));
      wr({`ISSTR_REG_AGING});
      rd(4, got);
      check(got[0], tv);
      check(got[1], ts[9:2]);
      check(got[2], {ts[1:0], 6'h00});
      check(got[3], 8'h00);
      pt = ts;
    end
    temp_sample = 10'($urandom());
    wait_done(25000);
    wr({`ISSTR_REG_TEMP_INT});
    rd(1, got);
    check(got[0], temp_sample[9:2]);
    for (int k = 0; k < 4; k++) begin
      adr = (k == 0) ? 8'hD2 : 8'($urandom());
      if (adr[7:1] == `ISSTR_SLAVE_ADDR)
        adr[7] = ~adr[7];
      isstr_i2c_master_inst.start();
      isstr_i2c_master_inst.byte_io(adr, 1'b1, r, a);
      check({7'h00, a}, 8'h01);
      isstr_i2c_master_inst.stop();
    end
    results();
  end
endmodule
